// ---- core/scmr_mailbox.v ----
// Host register slice, command interpreter and autonomous period timer of the sensor sequencer
`timescale 1ns/10ps
`include "scmr_consts.vh"

module scmr_mailbox #(
  parameter [31:0] UNIT_CYCLES = `SCMR_UNIT_CYCLES,
  parameter [7:0] REVISION_CODE = 8'h02
) (
  input wire i_ref_clk,
  input wire i_reset,
  input wire i_wr_en,
  input wire i_rd_en,
  input wire [7:0] i_addr,
  input wire [7:0] i_wr_data,
  input wire [5:0] i_overflow,
  output reg [7:0] o_rd_data,
  output reg o_awake,
  output reg o_measuring,
  output reg [5:0] o_channel_strobe,
  output reg [3:0] o_emitter_one_level,
  output reg [3:0] o_emitter_two_level,
  output reg [3:0] o_emitter_three_level,
  output reg [7:0] o_param_arg,
  output reg o_param_strobe,
  output reg o_irq_n_oe,
  output reg o_reset_cmd_strobe
);

  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_EXEC = 4'h2;
  localparam [3:0] ST_MEAS = 4'h4;
  localparam [3:0] ST_DONE = 4'h8;

  // Host-visible configuration
  reg [7:0] period_low_reg;
  reg [7:0] period_high_reg;
  reg [7:0] channel_list_reg;
  reg [7:0] irq_enable_reg;
  reg [7:0] emit21_reg;
  reg [3:0] emit3_reg;
  reg [7:0] param_reg;
  reg [7:0] command_reg;

  // Sequencer state; response is owned here, never by the host write path
  reg [7:0] response_reg;
  reg cmd_irq_reg;
  reg cmd_pending_reg;
  reg auto_run_reg;
  reg force_reg;
  reg [3:0] state_reg;

  // Period timer and measurement window
  reg [31:0] unit_cnt_reg;
  reg [15:0] period_cnt_reg;
  reg [4:0] meas_cnt_reg;
  reg [5:0] ovf_seen_reg;

  // Early sequencer revision lands period low at 0x0a and period high at 0x08, leaving 0x09 unmapped
  function [7:0] map_addr;
    input [7:0] addr;
    begin
      map_addr = addr;
      if (REVISION_CODE == `SCMR_EARLY_REVISION) begin
        if (addr == `SCMR_ADDR_PERIOD_LOW_ALT)
          map_addr = `SCMR_ADDR_PERIOD_LOW;
        else if (addr == `SCMR_ADDR_PERIOD_HIGH_ALT)
          map_addr = `SCMR_ADDR_PERIOD_HIGH;
        else if (addr == `SCMR_ADDR_PERIOD_HIGH)
          map_addr = 8'hff;
      end
    end
  endfunction

  // Lowest flagged overflow picks the error code
  function [7:0] overflow_code;
    input [5:0] ovf;
    begin
      if (ovf[0])
        overflow_code = `SCMR_ERR_PROX_ONE;
      else if (ovf[1])
        overflow_code = `SCMR_ERR_PROX_TWO;
      else if (ovf[2])
        overflow_code = `SCMR_ERR_PROX_THREE;
      else if (ovf[3])
        overflow_code = `SCMR_ERR_VISIBLE;
      else if (ovf[4])
        overflow_code = `SCMR_ERR_INFRARED;
      else
        overflow_code = `SCMR_ERR_AUX;
    end
  endfunction

  // No-op and reset are the only commands a held error lets through
  function is_clear_cmd;
    input [7:0] op;
    begin
      is_clear_cmd = (op == `SCMR_CMD_NOP) || (op == `SCMR_CMD_RESET);
    end
  endfunction

  // Address remap sits ahead of both the write decode and the read mux,
  // so the early revision is consistent on both paths
  wire [7:0] addr_m = map_addr(i_addr);
  wire [15:0] period_value = {period_high_reg, period_low_reg};
  wire error_held = response_reg[7];
  wire wake_tick = auto_run_reg && (period_value != 16'h0000) &&
                   (period_cnt_reg == 16'h0000) && (unit_cnt_reg == 32'h0);
  wire cmd_write = i_wr_en && (addr_m == `SCMR_ADDR_COMMAND);
  wire [7:0] resp_count = {4'h0, response_reg[3:0] + 4'h1};

  // Host register writes
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      period_low_reg <= `SCMR_RESET_VALUE;
      period_high_reg <= `SCMR_RESET_VALUE;
      channel_list_reg <= `SCMR_RESET_VALUE;
      irq_enable_reg <= `SCMR_RESET_VALUE;
      emit21_reg <= `SCMR_RESET_VALUE;
      emit3_reg <= 4'h0;
      param_reg <= `SCMR_RESET_VALUE;
      command_reg <= `SCMR_RESET_VALUE;
    end else if (i_wr_en) begin
      case (addr_m)
        `SCMR_ADDR_PERIOD_LOW: period_low_reg <= i_wr_data;
        `SCMR_ADDR_PERIOD_HIGH: period_high_reg <= i_wr_data;
        `SCMR_ADDR_CHANNEL_LIST: channel_list_reg <= i_wr_data;
        `SCMR_ADDR_IRQ_ENABLE: irq_enable_reg <= i_wr_data;
        `SCMR_ADDR_EMIT21: emit21_reg <= i_wr_data;
        `SCMR_ADDR_EMIT3: emit3_reg <= i_wr_data[3:0];
        `SCMR_ADDR_PARAM: param_reg <= i_wr_data;
        `SCMR_ADDR_COMMAND: command_reg <= i_wr_data;
        default: command_reg <= command_reg;
      endcase
    end
  end

  // Read mux; response stays host-readable, unmapped reads as zero
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rd_data <= 8'h00;
    end else if (i_rd_en) begin
      case (addr_m)
        `SCMR_ADDR_PERIOD_LOW: o_rd_data <= period_low_reg;
        `SCMR_ADDR_PERIOD_HIGH: o_rd_data <= period_high_reg;
        `SCMR_ADDR_CHANNEL_LIST: o_rd_data <= channel_list_reg;
        `SCMR_ADDR_IRQ_ENABLE: o_rd_data <= irq_enable_reg;
        `SCMR_ADDR_EMIT21: o_rd_data <= emit21_reg;
        `SCMR_ADDR_EMIT3: o_rd_data <= {4'h0, emit3_reg};
        `SCMR_ADDR_PARAM: o_rd_data <= param_reg;
        `SCMR_ADDR_COMMAND: o_rd_data <= command_reg;
        `SCMR_ADDR_RESPONSE: o_rd_data <= response_reg;
        `SCMR_ADDR_IRQ_STATUS: o_rd_data <= {2'b00, cmd_irq_reg, 5'h00};
        default: o_rd_data <= 8'h00;
      endcase
    end
  end

  // Autonomous period timer: one unit prescaler, then a period countdown
  // A zero period holds the timer at rest, so wake_tick never fires and autonomous mode never starts a measurement
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      unit_cnt_reg <= 32'h0;
      period_cnt_reg <= 16'h0000;
    end else if (!auto_run_reg) begin
      unit_cnt_reg <= 32'h0;
      period_cnt_reg <= 16'h0000;
    end else if (wake_tick) begin
      unit_cnt_reg <= UNIT_CYCLES - 32'h1;
      period_cnt_reg <= period_value - 16'h0001;
    end else if (unit_cnt_reg != 32'h0) begin
      unit_cnt_reg <= unit_cnt_reg - 32'h1;
    end else if (period_cnt_reg != 16'h0000) begin
      unit_cnt_reg <= UNIT_CYCLES - 32'h1;
      period_cnt_reg <= period_cnt_reg - 16'h0001;
    end
  end

  // Sequencer: commands queue behind a running measurement
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      state_reg <= ST_IDLE;
      response_reg <= `SCMR_RESET_VALUE;
      cmd_irq_reg <= 1'b0;
      cmd_pending_reg <= 1'b0;
      auto_run_reg <= 1'b0;
      force_reg <= 1'b0;
      meas_cnt_reg <= 5'h00;
      ovf_seen_reg <= 6'h00;
      o_awake <= 1'b0;
      o_measuring <= 1'b0;
      o_channel_strobe <= 6'h00;
      o_param_arg <= 8'h00;
      o_param_strobe <= 1'b0;
      o_reset_cmd_strobe <= 1'b0;
    end else begin
      o_channel_strobe <= 6'h00;
      o_param_strobe <= 1'b0;
      o_reset_cmd_strobe <= 1'b0;
      if (cmd_write)
        cmd_pending_reg <= 1'b1;
      if (i_wr_en && addr_m == `SCMR_ADDR_IRQ_STATUS && i_wr_data[`SCMR_CMD_IRQ_BIT])
        cmd_irq_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          // Wake has priority; a command written meanwhile stays pending
          if (wake_tick) begin
            state_reg <= ST_MEAS;
            o_awake <= 1'b1;
            o_measuring <= 1'b1;
            o_channel_strobe <= channel_list_reg[5:0];
            meas_cnt_reg <= 5'h00;
            ovf_seen_reg <= 6'h00;
          end else if (cmd_pending_reg || cmd_write) begin
            state_reg <= ST_EXEC;
            o_awake <= 1'b1;
          end else begin
            o_awake <= auto_run_reg;
          end
        end
        ST_MEAS: begin
          ovf_seen_reg <= ovf_seen_reg | (i_overflow & channel_list_reg[5:0]);
          meas_cnt_reg <= meas_cnt_reg + 5'h01;
          if (meas_cnt_reg == `SCMR_MEAS_CYCLES - 1) begin
            state_reg <= ST_DONE;
            o_measuring <= 1'b0;
          end
        end
        ST_DONE: begin
          // A forced measurement only counts as executed once it has finished
          if (ovf_seen_reg != 6'h00 && !error_held) begin
            response_reg <= overflow_code(ovf_seen_reg);
            cmd_irq_reg <= 1'b1;
          end else if (force_reg && !error_held) begin
            response_reg <= resp_count;
            cmd_irq_reg <= 1'b1;
          end
          force_reg <= 1'b0;
          state_reg <= ST_IDLE;
        end
        ST_EXEC: begin
          cmd_pending_reg <= cmd_write;
          state_reg <= ST_IDLE;
          // Counter advances only for commands that really ran
          if (is_clear_cmd(command_reg)) begin
            response_reg <= `SCMR_RESET_VALUE;
            cmd_irq_reg <= 1'b1;
            if (command_reg == `SCMR_CMD_RESET) begin
              auto_run_reg <= 1'b0;
              o_reset_cmd_strobe <= 1'b1;
            end
          end else if (error_held) begin
            response_reg <= response_reg;
          end else begin
            cmd_irq_reg <= 1'b1;
            case (command_reg)
              `SCMR_CMD_PARAM_SET: begin
                o_param_arg <= param_reg;
                o_param_strobe <= 1'b1;
                response_reg <= resp_count;
              end
              `SCMR_CMD_AUTO_START: begin
                auto_run_reg <= 1'b1;
                response_reg <= resp_count;
              end
              `SCMR_CMD_AUTO_STOP: begin
                auto_run_reg <= 1'b0;
                response_reg <= resp_count;
              end
              `SCMR_CMD_FORCE: begin
                // Runs a real measurement so overflow can be reported for it
                o_channel_strobe <= channel_list_reg[5:0];
                state_reg <= ST_MEAS;
                o_measuring <= 1'b1;
                meas_cnt_reg <= 5'h00;
                ovf_seen_reg <= 6'h00;
                force_reg <= 1'b1;
              end
              default: response_reg <= `SCMR_ERR_INVALID;
            endcase
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Emitter drives are only live while measuring; field code passes straight to the DAC
  // One cycle lag against o_measuring is accepted to keep every output registered
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_emitter_one_level <= 4'h0;
      o_emitter_two_level <= 4'h0;
      o_emitter_three_level <= 4'h0;
      o_irq_n_oe <= 1'b0;
    end else begin
      o_emitter_one_level <= o_measuring ? emit21_reg[3:0] : 4'h0;
      o_emitter_two_level <= o_measuring ? emit21_reg[7:4] : 4'h0;
      o_emitter_three_level <= o_measuring ? emit3_reg : 4'h0;
      o_irq_n_oe <= cmd_irq_reg && irq_enable_reg[`SCMR_CMD_IRQ_BIT];
    end
  end

endmodule // scmr_mailbox

// ---- core/scmr_consts.vh ----
// Register offsets, field positions, response codes and timing counts for the mailbox block
`ifndef SCMR_CONSTS_VH
`define SCMR_CONSTS_VH
`define SCMR_ADDR_PERIOD_LOW 8'h08
`define SCMR_ADDR_PERIOD_HIGH 8'h09
`define SCMR_ADDR_PERIOD_LOW_ALT 8'h0a
`define SCMR_ADDR_PERIOD_HIGH_ALT 8'h08
`define SCMR_ADDR_CHANNEL_LIST 8'h01
`define SCMR_ADDR_IRQ_ENABLE 8'h04
`define SCMR_ADDR_EMIT21 8'h0f
`define SCMR_ADDR_EMIT3 8'h10
`define SCMR_ADDR_PARAM 8'h17
`define SCMR_ADDR_COMMAND 8'h18
`define SCMR_ADDR_RESPONSE 8'h20
`define SCMR_ADDR_IRQ_STATUS 8'h21
`define SCMR_RESET_VALUE 8'h00
`define SCMR_EMIT_TWO_MSB 7
`define SCMR_EMIT_TWO_LSB 4
`define SCMR_EMIT_ONE_MSB 3
`define SCMR_EMIT_ONE_LSB 0
`define SCMR_CMD_IRQ_BIT 5
`define SCMR_CMD_NOP 8'h00
`define SCMR_CMD_RESET 8'h01
`define SCMR_CMD_PARAM_SET 8'ha0
`define SCMR_CMD_AUTO_START 8'h0f
`define SCMR_CMD_AUTO_STOP 8'h0b
`define SCMR_CMD_FORCE 8'h07
`define SCMR_ERR_INVALID 8'h80
`define SCMR_ERR_PROX_ONE 8'h88
`define SCMR_ERR_PROX_TWO 8'h89
`define SCMR_ERR_PROX_THREE 8'h8a
`define SCMR_ERR_VISIBLE 8'h8c
`define SCMR_ERR_INFRARED 8'h8d
`define SCMR_ERR_AUX 8'h8e
`define SCMR_EARLY_REVISION 8'h01
`define SCMR_CLK_HZ 100000000
`define SCMR_PERIOD_UNIT_US 31250
`define SCMR_UNIT_CYCLES ((`SCMR_CLK_HZ / 1000000) * `SCMR_PERIOD_UNIT_US)
`define SCMR_MEAS_CYCLES 16
`endif

// ---- sim/scmr_monitor.sv ----
// Port-level assertions for the mailbox block
`timescale 1ns/10ps
module scmr_monitor (
  input wire i_ref_clk,
  input wire i_reset,
  input wire i_wr_en,
  input wire i_rd_en,
  input wire [7:0] i_addr,
  input wire [7:0] i_wr_data,
  input wire [5:0] i_overflow,
  input wire [7:0] o_rd_data,
  input wire o_awake,
  input wire o_measuring,
  input wire [5:0] o_channel_strobe,
  input wire [3:0] o_emitter_one_level,
  input wire [3:0] o_emitter_two_level,
  input wire [3:0] o_emitter_three_level,
  input wire [7:0] o_param_arg,
  input wire o_param_strobe,
  input wire o_irq_n_oe,
  input wire o_reset_cmd_strobe
);
  reg [7:0] emit21_reg, emit3_reg, mbox_reg, chl_reg, resp_reg;
  reg ie_reg, cmd_seen_reg, clr_seen_reg, rd_resp_reg;
  wire wr_cmd = i_wr_en && i_addr == 8'h18;
  // Shadow copies are taken from host writes, except the response copy, which is taken from the block's read data
  always @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      {emit21_reg, emit3_reg, mbox_reg, chl_reg, resp_reg} <= 40'h0;
      {ie_reg, cmd_seen_reg, clr_seen_reg, rd_resp_reg} <= 4'h0;
    end else begin
      rd_resp_reg <= i_rd_en && i_addr == 8'h20;
      if (rd_resp_reg)
        resp_reg <= o_rd_data;
      if (rd_resp_reg && !o_rd_data[7])
        clr_seen_reg <= 1'h0;
      if (i_wr_en && i_addr == 8'h0f)
        emit21_reg <= i_wr_data;
      if (i_wr_en && i_addr == 8'h10)
        emit3_reg <= i_wr_data;
      if (i_wr_en && i_addr == 8'h17)
        mbox_reg <= i_wr_data;
      if (i_wr_en && i_addr == 8'h01)
        chl_reg <= i_wr_data;
      if (i_wr_en && i_addr == 8'h04)
        ie_reg <= i_wr_data[5];
      if (wr_cmd)
        cmd_seen_reg <= 1'h1;
      if (wr_cmd && i_wr_data < 8'h02)
        clr_seen_reg <= 1'h1;
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  a_emit_one_level: assert property (o_measuring && $past(o_measuring) |->
    o_emitter_one_level == emit21_reg[3:0]) else $error("emitter one level wrong");
  a_emit_two_level: assert property (o_measuring && $past(o_measuring) |->
    o_emitter_two_level == emit21_reg[7:4]) else $error("emitter two level wrong");
  a_emit_three_level: assert property (o_measuring && $past(o_measuring) |->
    o_emitter_three_level == emit3_reg[3:0]) else $error("emitter three level wrong");
  a_emit_idle_off: assert property (!o_measuring && !$past(o_measuring) |->
    {o_emitter_one_level, o_emitter_two_level, o_emitter_three_level} == 12'h0)
    else $error("emitter current outside measurement");
  a_wake_after_cmd: assert property ($rose(o_awake) |-> cmd_seen_reg)
    else $error("left standby without a command write");
  a_param_from_mbox: assert property (o_param_strobe |-> o_param_arg == mbox_reg)
    else $error("parameter argument differs from mailbox");
  a_err_code_held: assert property (rd_resp_reg && resp_reg[7] && !clr_seen_reg |->
    o_rd_data == resp_reg) else $error("held error code changed");
  a_resp_code_set: assert property (rd_resp_reg |-> o_rd_data <= 8'h0f ||
    o_rd_data inside {8'h80, 8'h88, 8'h89, 8'h8a, 8'h8c, 8'h8d, 8'h8e})
    else $error("response value outside defined codes");
  a_strobe_chan_list: assert property (|o_channel_strobe |->
    o_channel_strobe == chl_reg[5:0]) else $error("strobed channels differ from list");
  a_irq_needs_en: assert property (o_irq_n_oe |-> ie_reg || $past(ie_reg))
    else $error("interrupt driven while disabled");
  cover property (o_param_strobe);
  cover property (o_irq_n_oe);
  cover property (o_reset_cmd_strobe);
  cover property (rd_resp_reg && o_rd_data[7]);
endmodule // scmr_monitor
bind scmr_mailbox scmr_monitor scmr_monitor_inst (.*);

// ---- sim/scmr_host.sv ----
// Host model that issues single byte transfers on the register port
`timescale 1ns/10ps
module scmr_host #(
  parameter SINGLE_EMITTER = 0
) (
  input wire i_ref_clk,
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [7:0] o_addr,
  output logic [7:0] o_wr_data
);
  initial begin
    {o_wr_en, o_rd_en, o_addr, o_wr_data} = 18'h0;
  end
  // Idle address and data are inverted so a stale value never looks live
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] dd;
    dd = d;
    if (SINGLE_EMITTER != 0 && wr && a == 8'h0f)
      dd[7:4] = 4'h0;
    @(posedge i_ref_clk);
    o_wr_en <= wr;
    o_rd_en <= !wr;
    o_addr <= a;
    o_wr_data <= dd;
    @(posedge i_ref_clk);
    o_wr_en <= 1'h0;
    o_rd_en <= 1'h0;
    o_addr <= ~a;
    o_wr_data <= ~dd;
  endtask
endmodule // scmr_host

// ---- sim/testbench.sv ----
// Self-checking bench for the mailbox block driven through the host model
`timescale 1ns/10ps
module testbench;
  localparam logic [63:0] REGS = 64'h3020_1808_1710_0f09;
  localparam logic [47:0] OVF_CODES = 48'h8e8d8c8a8988;
  logic i_ref_clk = 1'h0;
  logic i_reset = 1'h1;
  logic i_wr_en, i_rd_en, o_awake, o_measuring, o_param_strobe, o_irq_n_oe;
  logic o_reset_cmd_strobe, rd_q1 = 1'h0;
  logic [7:0] i_addr, i_wr_data, o_rd_data, o_param_arg, v;
  logic [5:0] i_overflow = 6'h0, o_channel_strobe;
  logic [3:0] o_emitter_one_level, o_emitter_two_level, o_emitter_three_level;
  logic [8:0] exp_q[$];
  logic [8:0] e;
  logic [31:0] seed = 32'h2388b2fe;
  int errors = 0, check_count = 0, cyc = 0, t1;
  always #5 i_ref_clk = ~i_ref_clk;
  scmr_mailbox #(.UNIT_CYCLES(32'h4)) scmr_mailbox_inst (.*);
  scmr_host scmr_host_inst (.i_ref_clk(i_ref_clk), .o_wr_en(i_wr_en), .o_rd_en(i_rd_en),
    .o_addr(i_addr), .o_wr_data(i_wr_data));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    scmr_host_inst.xfer(1'h1, a, d);
  endtask
  // Bit 8 of a note marks a poll whose value is not compared
  task automatic rd(input logic [7:0] a, input logic [8:0] ex);
    exp_q.push_back(ex);
    scmr_host_inst.xfer(1'h0, a, 8'h00);
  endtask
  task automatic peek(input logic [7:0] a);
    rd(a, 9'h100);
    @(negedge i_ref_clk);
    v = o_rd_data;
  endtask
  task automatic cmd(input logic [7:0] op);
    logic [7:0] old;
    peek(8'h20);
    old = v;
    wr(8'h18, op);
    for (int n = 0; n < 40 && v == old; n++)
      peek(8'h20);
  endtask
  task automatic wait_strobe();
    int n;
    n = 0;
    do @(negedge i_ref_clk); while (o_channel_strobe === 6'h0 && ++n < 3000);
  endtask
  always @(posedge i_ref_clk) begin
    rd_q1 <= i_rd_en;
    cyc <= cyc + 1;
    if (rd_q1) begin
      e = exp_q.pop_front();
      if (!e[8])
        check(o_rd_data, e[7:0]);
    end
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end
  initial begin
    repeat (5) @(posedge i_ref_clk);
    i_reset <= 1'h0;
    for (int k = 0; k < 8; k++)
      rd(REGS[8*k +: 8], 9'h000);
    $display("test reset_values done");
    for (int k = 0; k < 5; k++) begin
      seed = lfsr(seed);
      v = seed[7:0] & ((k == 2) ? 8'h0f : 8'hff);
      wr(REGS[8*k +: 8], v);
      rd(REGS[8*k +: 8], {1'h0, v});
    end
    check({7'h0, o_awake}, 8'h00);
    $display("test readback done");
    wr(8'h01, 8'h3f);
    wr(8'h04, 8'h20);
    for (int k = 1; k <= 17; k++) begin
      cmd((k % 2) ? 8'h07 : 8'ha0);
      rd(8'h20, {5'h0, k[3:0]});
    end
    check({7'h0, o_awake}, 8'h00);
    check({7'h0, o_irq_n_oe}, 8'h01);
    wr(8'h21, 8'h20);
    repeat (3) @(posedge i_ref_clk);
    check({7'h0, o_irq_n_oe}, 8'h00);
    $display("test command_counter done");
    cmd(8'h55);
    rd(8'h20, 9'h080);
    cmd(8'h07);
    rd(8'h20, 9'h080);
    for (int k = 0; k < 6; k++) begin
      cmd((k % 2) ? 8'h00 : 8'h01);
      rd(8'h20, 9'h000);
      @(posedge i_ref_clk);
      i_overflow <= 6'h1 << k;
      cmd(8'h07);
      rd(8'h20, {1'h0, OVF_CODES[8*k +: 8]});
      @(posedge i_ref_clk);
      i_overflow <= 6'h0;
    end
    cmd(8'h00);
    $display("test error_codes done");
    wr(8'h08, 8'h02);
    wr(8'h09, 8'h01);
    cmd(8'h0f);
    wait_strobe();
    t1 = cyc;
    @(posedge i_ref_clk);
    i_overflow <= 6'h01;
    wait_strobe();
    check(8'(cyc - t1 - 1032), 8'h00);
    rd(8'h20, 9'h088);
    @(posedge i_ref_clk);
    i_overflow <= 6'h0;
    cmd(8'h00);
    cmd(8'h0b);
    $display("test autonomous done");
    close_out();
  end
endmodule // testbench
